// File: rtl/brs_seq.sv
// The register addresses and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module brs_seq
    import brs_pkg::*;
(
    input  wire logic mclk,
    input  wire logic srst,
    brs_cfg_if.seq    cfg,
    input  wire logic run_cmd_i,
    input  wire logic reversal_i,
    input  wire logic contact_i,
    input  wire logic relay_fb_i,
    output logic      brake_release_o,
    output logic      ref_enable_o,
    output logic      ramp_down_o,
    output logic      zero_hold_o,
    output logic      fb_error_o,
    output logic      jump_enable_o
);
    brs_state_t  state_r, state_nxt;
    logic [18:0] tick_r;
    logic [10:0] cnt_r, cnt_nxt;
    logic        prev_contact_r, pend_r, pend_nxt;
    logic        prev_run_r;

    wire assigned  = cfg.ctl[CTL_ASSIGN];
    wire mode1     = cfg.ctl[CTL_RESTART];
    wire contact_m = cfg.ctl[CTL_CONTACT] & cfg.ctl[CTL_CONTACT_IN];
    wire tick      = (tick_r == TICK_LAST);
    wire expired   = (cnt_r == 11'h000);
    wire rise      = contact_i & ~prev_contact_r;
    wire fall      = ~contact_i & prev_contact_r;
    // in the engage delay only a fresh run counts as a new command; a run held through a reversal does not
    wire run_rise  = run_cmd_i & ~prev_run_r;
    wire rev_eng   = cfg.ctl[CTL_REVERSAL] & reversal_i;
    wire not_open  = contact_i | relay_fb_i;
    wire miss      = (state_r == BRS_ENG_TIME) & expired & not_open & cfg.ctl[CTL_CLOSED];
    wire steady    = (state_r == BRS_RUN) & ~contact_i & ~cfg.ctl[CTL_STEADY];

    // restart interval clamped to its 15.00 s ceiling
    wire [10:0] rst_lim = (cfg.rst_int > RST_INT_MAX) ? RST_INT_MAX : cfg.rst_int;

    // 10 ms timebase
    always_ff @(posedge mclk) begin
        tick_r         <= (srst | tick) ? 19'h00000 : tick_r + 19'h00001;
        prev_contact_r <= srst ? 1'b0 : contact_i;
        prev_run_r     <= srst ? 1'b0 : run_cmd_i;
    end

    // phase sequencing
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = (tick && !expired) ? cnt_r - 11'h001 : cnt_r;
        pend_nxt  = pend_r;
        case (state_r)
            BRS_IDLE: if (run_cmd_i) begin
                state_nxt = BRS_RELEASE;
                cnt_nxt   = cfg.rel_dur;
            end
            BRS_RELEASE: if (contact_m ? rise : expired) begin
                state_nxt = BRS_RUN;
            end
            BRS_RUN: if (rev_eng || !run_cmd_i) begin
                state_nxt = BRS_ENG_DLY;
                cnt_nxt   = cfg.eng_dly;
            end
            BRS_ENG_DLY: if (run_rise && (mode1 || cfg.ctl[CTL_REVERSAL])) begin
                state_nxt = cfg.ctl[CTL_REVERSAL] ? BRS_RELEASE : BRS_RUN;
                cnt_nxt   = cfg.rel_dur;
            end else if (expired) begin
                state_nxt = BRS_ENG_TIME;
                cnt_nxt   = cfg.eng_dur;
            end
            BRS_ENG_TIME: begin
                if (run_cmd_i && mode1) pend_nxt = 1'b1;
                if (contact_m ? fall : expired) begin
                    state_nxt = BRS_RAMP;
                    cnt_nxt   = cfg.ramp_dur;
                end
            end
            BRS_RAMP: if (pend_r) begin
                state_nxt = BRS_RELEASE;
                cnt_nxt   = cfg.rel_dur;
                pend_nxt  = 1'b0;
            end else if (expired) begin
                state_nxt = BRS_RESTART;
                cnt_nxt   = rst_lim;
            end
            BRS_RESTART: if (run_cmd_i) begin
                state_nxt = BRS_RELEASE;
                cnt_nxt   = cfg.rel_dur;
            end else if (expired) begin
                state_nxt = BRS_IDLE;
            end
            default: state_nxt = BRS_IDLE;
        endcase
        if (!assigned) begin
            state_nxt = BRS_IDLE;
            pend_nxt  = 1'b0;
        end
    end

    // registers of the sequence; counters are phase timers
    always_ff @(posedge mclk) begin
        state_r <= srst ? BRS_IDLE : state_nxt;
        cnt_r   <= srst ? 11'h000 : cnt_nxt;
        pend_r  <= srst ? 1'b0 : pend_nxt;
    end

    // outputs from flops; error locks until reset
    always_ff @(posedge mclk) begin
        if (srst) begin
            brake_release_o <= 1'b0;
            ref_enable_o    <= 1'b0;
            ramp_down_o     <= 1'b0;
            zero_hold_o     <= 1'b0;
            fb_error_o      <= 1'b0;
            jump_enable_o   <= 1'b0;
        end else begin
            brake_release_o <= (state_nxt == BRS_RELEASE) | (state_nxt == BRS_RUN)
                             | (state_nxt == BRS_ENG_DLY);
            ref_enable_o    <= (state_nxt == BRS_RUN);
            ramp_down_o     <= (state_nxt == BRS_RAMP);
            zero_hold_o     <= zero_hold_o ? run_cmd_i == 1'b0
                             : miss & cfg.ctl[CTL_MISSING];
            fb_error_o      <= fb_error_o | (miss & ~cfg.ctl[CTL_MISSING])
                             | (steady & assigned);
            jump_enable_o   <= ~cfg.ctl[CTL_REVERSAL] & cfg.ctl[CTL_HOIST]
                             & ~cfg.ctl[CTL_CLOSED];
        end
    end

    assign cfg.state  = 3'(state_r);
    assign cfg.events = {(state_r == BRS_RESTART) & run_cmd_i, steady,
                         miss & cfg.ctl[CTL_MISSING], miss & ~cfg.ctl[CTL_MISSING]};
endmodule

// File: pkg/brs_pkg.sv
package brs_pkg;
    // clock rate and cycles per 10 ms tick of the time settings
    localparam int unsigned CLK_HZ          = 40000000;
    localparam int unsigned TICK_MS         = 10;
    localparam int unsigned TICK_CYC        = CLK_HZ / 1000 * TICK_MS;
    localparam logic [18:0] TICK_LAST       = 19'(TICK_CYC - 1);

    // register byte offsets
    localparam logic [7:0]  OFS_CTRL        = 8'h00;
    localparam logic [7:0]  OFS_REL_DUR     = 8'h04;
    localparam logic [7:0]  OFS_ENG_DLY     = 8'h08;
    localparam logic [7:0]  OFS_ENG_DUR     = 8'h0c;
    localparam logic [7:0]  OFS_RST_INT     = 8'h10;
    localparam logic [7:0]  OFS_RAMP_DUR    = 8'h14;
    localparam logic [7:0]  OFS_STATUS      = 8'h18;
    localparam logic [7:0]  OFS_IRQ_STAT    = 8'h1c;
    localparam logic [7:0]  OFS_IRQ_MASK    = 8'h20;

    // control field positions
    localparam int unsigned CTL_ASSIGN      = 0;
    localparam int unsigned CTL_REVERSAL    = 1;
    localparam int unsigned CTL_RESTART     = 2;
    localparam int unsigned CTL_STEADY      = 3;
    localparam int unsigned CTL_CONTACT     = 4;
    localparam int unsigned CTL_MISSING     = 5;
    localparam int unsigned CTL_HOIST       = 6;
    localparam int unsigned CTL_CLOSED      = 7;
    localparam int unsigned CTL_CONTACT_IN  = 8;
    localparam int unsigned CTL_WIDTH       = 9;

    // reset values, durations in 10 ms ticks
    localparam logic [CTL_WIDTH-1:0] CTL_RST = 9'h000;
    localparam logic [10:0] REL_DUR_RST     = 11'h032;   // 0.50 s
    localparam logic [10:0] ENG_DLY_RST     = 11'h000;   // 0.00 s
    localparam logic [10:0] ENG_DUR_RST     = 11'h032;   // 0.50 s
    localparam logic [10:0] RST_INT_RST     = 11'h000;   // 0.00 s
    localparam logic [10:0] RAMP_DUR_RST    = 11'h000;
    localparam logic [10:0] RST_INT_MAX     = 11'h5dc;   // 15.00 s

    // interrupt bit positions
    localparam int unsigned IRQ_FB_ERR      = 0;
    localparam int unsigned IRQ_WARN        = 1;
    localparam int unsigned IRQ_STEADY      = 2;
    localparam int unsigned IRQ_RESTART     = 3;
    localparam int unsigned IRQ_WIDTH       = 4;

    typedef enum logic [2:0] {
        BRS_IDLE, BRS_RELEASE, BRS_RUN, BRS_ENG_DLY, BRS_ENG_TIME, BRS_RAMP, BRS_RESTART
    } brs_state_t;
endpackage

// File: pkg/brs_cfg_if.sv
`timescale 1ns/1ps
// settings handed from the register file to the sequencer
interface brs_cfg_if;
    logic [brs_pkg::CTL_WIDTH-1:0] ctl;
    logic [10:0]                   rel_dur;
    logic [10:0]                   eng_dly;
    logic [10:0]                   eng_dur;
    logic [10:0]                   rst_int;
    logic [10:0]                   ramp_dur;
    logic [2:0]                    state;
    logic [3:0]                    events;
    modport regs (output ctl, rel_dur, eng_dly, eng_dur, rst_int, ramp_dur, input state, events);
    modport seq  (input ctl, rel_dur, eng_dly, eng_dur, rst_int, ramp_dur, output state, events);
endinterface

// File: rtl/brs_top.sv
`timescale 1ns/1ps
// How it works
// - reversal engage on: brake engages at zero crossing; off by default
// - jump frequency ignored if reversal engage; else only hoisting open loop
// - restart interval, up to 15.00 s, default 0, between sequences
// - run during restart interval restarts whole sequence
// - run while reversal engage active restarts whole sequence
// - restart mode 0: full engage then full release
// - mode 1: run before engage delay ends acts at once
// - mode 1: run during engage time acts when engage time ends
// - mode 1: run after engage time waits for sequence end
// - steady check 0: contact open in operation raises error
// - steady check 1: no steady error, only release and engage phases
// - contact select 0: reference at release end, ramp at engage end
// - contact select 1 with CTL_CONTACT_IN set: contact rise enables reference, fall starts ramp
// - engage delay, default 0, before requesting brake engage
// - closed loop: contact not open at engage end: error or warn and hold
module brs_top
    import brs_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        run_cmd,
    input  wire logic        reversal,
    input  wire logic        brake_contact_input,
    input  wire logic        relay_feedback,
    output logic             brake_release,
    output logic             reference_enable,
    output logic             current_ramp_down,
    output logic             zero_speed_hold,
    output logic             brake_feedback_error,
    output logic             reversal_jump_frequency_en,
    output logic             irq
);
    brs_cfg_if cfg ();

    // --------------------------------------------------------------
    // input synchronisers
    // --------------------------------------------------------------
    logic [2:0] run_s_r, rev_s_r, con_s_r, rly_s_r;
    logic       run_q_r, rev_q_r, con_q_r, rly_q_r;

    // a change counts once stages two and three agree
    always_ff @(posedge mclk) begin
        run_s_r <= srst ? 3'h0 : {run_s_r[1:0], run_cmd};
        rev_s_r <= srst ? 3'h0 : {rev_s_r[1:0], reversal};
        con_s_r <= srst ? 3'h0 : {con_s_r[1:0], brake_contact_input};
        rly_s_r <= srst ? 3'h0 : {rly_s_r[1:0], relay_feedback};
        run_q_r <= srst ? 1'b0 : (run_s_r[2] == run_s_r[1]) ? run_s_r[2] : run_q_r;
        rev_q_r <= srst ? 1'b0 : (rev_s_r[2] == rev_s_r[1]) ? rev_s_r[2] : rev_q_r;
        con_q_r <= srst ? 1'b0 : (con_s_r[2] == con_s_r[1]) ? con_s_r[2] : con_q_r;
        rly_q_r <= srst ? 1'b0 : (rly_s_r[2] == rly_s_r[1]) ? rly_s_r[2] : rly_q_r;
    end

    // --------------------------------------------------------------
    // ahb-lite slave
    // --------------------------------------------------------------
    logic                 wr_pend_r;
    logic [7:0]           wr_ofs_r;
    logic [CTL_WIDTH-1:0] ctl_r;
    logic [10:0]          rel_r, edly_r, edur_r, rint_r, ramp_r;
    logic [IRQ_WIDTH-1:0] ist_r, imask_r;

    // address phase decode; only whole-word single transfers are used
    wire        take     = hsel & hready & htrans[1];
    wire [7:0]  ofs      = {haddr[7:2], 2'b00};
    wire        do_wr    = wr_pend_r;
    wire        wr_ctl   = do_wr & (wr_ofs_r == OFS_CTRL);
    wire        wr_rel   = do_wr & (wr_ofs_r == OFS_REL_DUR);
    wire        wr_edly  = do_wr & (wr_ofs_r == OFS_ENG_DLY);
    wire        wr_edur  = do_wr & (wr_ofs_r == OFS_ENG_DUR);
    wire        wr_rint  = do_wr & (wr_ofs_r == OFS_RST_INT);
    wire        wr_ramp  = do_wr & (wr_ofs_r == OFS_RAMP_DUR);
    wire        wr_ist   = do_wr & (wr_ofs_r == OFS_IRQ_STAT);
    wire        wr_imask = do_wr & (wr_ofs_r == OFS_IRQ_MASK);
    wire [IRQ_WIDTH-1:0] ist_clr = wr_ist ? hwdata[IRQ_WIDTH-1:0] : '0;
    // interval stored clamped, so software reads back what the sequencer uses
    wire [10:0]          rint_wr = (hwdata[10:0] > RST_INT_MAX) ? RST_INT_MAX : hwdata[10:0];

    // read mux; unmapped offsets read zero
    logic [31:0] rd_mux;
    always_comb begin
        case (ofs)
            OFS_CTRL:     rd_mux = {23'h0, ctl_r};
            OFS_REL_DUR:  rd_mux = {21'h0, rel_r};
            OFS_ENG_DLY:  rd_mux = {21'h0, edly_r};
            OFS_ENG_DUR:  rd_mux = {21'h0, edur_r};
            OFS_RST_INT:  rd_mux = {21'h0, rint_r};
            OFS_RAMP_DUR: rd_mux = {21'h0, ramp_r};
            OFS_STATUS:   rd_mux = {26'h0, zero_speed_hold, brake_feedback_error,
                                    1'b0, cfg.state};
            OFS_IRQ_STAT: rd_mux = {28'h0, ist_r};
            OFS_IRQ_MASK: rd_mux = {28'h0, imask_r};
            default:      rd_mux = 32'h0;
        endcase
    end

    // bus phase tracking; always ready, always okay
    always_ff @(posedge mclk) begin
        wr_pend_r <= srst ? 1'b0 : take & hwrite;
        wr_ofs_r  <= srst ? 8'h00 : (take ? ofs : wr_ofs_r);
        hrdata    <= srst ? 32'h0 : ((take & ~hwrite) ? rd_mux : hrdata);
        hreadyout <= 1'b1;
        hresp     <= 1'b0;
    end

    // settings registers
    always_ff @(posedge mclk) begin
        ctl_r   <= srst ? CTL_RST      : (wr_ctl  ? hwdata[CTL_WIDTH-1:0] : ctl_r);
        rel_r   <= srst ? REL_DUR_RST  : (wr_rel  ? hwdata[10:0] : rel_r);
        edly_r  <= srst ? ENG_DLY_RST  : (wr_edly ? hwdata[10:0] : edly_r);
        edur_r  <= srst ? ENG_DUR_RST  : (wr_edur ? hwdata[10:0] : edur_r);
        rint_r  <= srst ? RST_INT_RST  : (wr_rint ? rint_wr : rint_r);
        ramp_r  <= srst ? RAMP_DUR_RST : (wr_ramp ? hwdata[10:0] : ramp_r);
        imask_r <= srst ? '0 : (wr_imask ? hwdata[IRQ_WIDTH-1:0] : imask_r);
    end

    // --------------------------------------------------------------
    // interrupts: set wins over write-one clear
    // --------------------------------------------------------------
    always_ff @(posedge mclk) begin
        ist_r <= srst ? '0 : ((ist_r & ~ist_clr) | cfg.events);
        irq   <= srst ? 1'b0 : |(((ist_r & ~ist_clr) | cfg.events) & imask_r);
    end

    assign cfg.ctl      = ctl_r;
    assign cfg.rel_dur  = rel_r;
    assign cfg.eng_dly  = edly_r;
    assign cfg.eng_dur  = edur_r;
    assign cfg.rst_int  = rint_r;
    assign cfg.ramp_dur = ramp_r;

    // --------------------------------------------------------------
    // sequencer
    // --------------------------------------------------------------
    brs_seq u_seq (
        .mclk            (mclk),
        .srst            (srst),
        .cfg             (cfg),
        .run_cmd_i       (run_q_r),
        .reversal_i      (rev_q_r),
        .contact_i       (con_q_r),
        .relay_fb_i      (rly_q_r),
        .brake_release_o (brake_release),
        .ref_enable_o    (reference_enable),
        .ramp_down_o     (current_ramp_down),
        .zero_hold_o     (zero_speed_hold),
        .fb_error_o      (brake_feedback_error),
        .jump_enable_o   (reversal_jump_frequency_en)
    );
endmodule

// File: sim/brs_chk.sv
`timescale 1ns/1ps
// ------------
// port checker
// ------------
module brs_chk
    import brs_pkg::*;
(
    input wire logic        mclk,
    input wire logic        srst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        brake_release,
    input wire logic        reference_enable,
    input wire logic        current_ramp_down,
    input wire logic        brake_feedback_error,
    input wire logic        reversal_jump_frequency_en,
    input wire logic        irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    // transfer decode, same taking edge as the slave
    wire        take = hsel && hready && htrans[1];
    logic       ctl_wr_r;
    logic       unm_rd_r;
    logic [8:0] ctl_r;
    logic [2:0] age_r;
    // shadow of the control word; age gives the settings time to settle
    always_ff @(posedge mclk) begin
        if (srst) begin
            ctl_wr_r <= 1'b0;
            unm_rd_r <= 1'b0;
            ctl_r    <= '0;
            age_r    <= '0;
        end else begin
            ctl_wr_r <= take && hwrite && haddr[7:0] == OFS_CTRL;
            unm_rd_r <= take && !hwrite && haddr[7:0] > OFS_IRQ_MASK;
            ctl_r    <= ctl_wr_r ? hwdata[8:0] : ctl_r;
            age_r    <= ctl_wr_r ? 3'd0 : (age_r == 3'd7 ? age_r : age_r + 3'd1);
        end
    end
    property p_ready; hreadyout && !hresp; endproperty
    a_ready: assert property (p_ready) else $error("bus stalled or errored");
    property p_unmapped; unm_rd_r |-> hrdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_idle;
        !ctl_r[CTL_ASSIGN] && age_r == 3'd7 |-> !brake_release && !reference_enable;
    endproperty
    a_idle: assert property (p_idle) else $error("brake command while unassigned");
    property p_jump;
        reversal_jump_frequency_en && age_r == 3'd7
            |-> ctl_r[CTL_HOIST] && !ctl_r[CTL_CLOSED] && !ctl_r[CTL_REVERSAL];
    endproperty
    a_jump: assert property (p_jump) else $error("jump enabled wrongly");
    property p_ref; reference_enable |-> brake_release; endproperty
    a_ref: assert property (p_ref) else $error("reference with brake engaged");
    property p_ramp; current_ramp_down |-> !brake_release && !reference_enable; endproperty
    a_ramp: assert property (p_ramp) else $error("ramp outside engage");
    property p_lock; brake_feedback_error |=> brake_feedback_error; endproperty
    a_lock: assert property (p_lock) else $error("feedback error dropped");
    property p_rst; $past(srst) |-> !brake_release && !irq && !brake_feedback_error; endproperty
    a_rst: assert property (p_rst) else $error("output active after reset");
    c_ref: cover property ($rose(reference_enable));
    c_ramp: cover property ($rose(current_ramp_down));
    c_err: cover property ($rose(brake_feedback_error));
    c_irq: cover property ($rose(irq));
endmodule
bind brs_top brs_chk u_chk (
    .mclk, .srst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout,
    .hresp, .brake_release, .reference_enable, .current_ramp_down, .brake_feedback_error,
    .reversal_jump_frequency_en, .irq
);

// File: sim/brs_brake_model.sv
`timescale 1ns/1ps
// ----------------------------
// brake relay and contact model
// ----------------------------
module brs_brake_model #(
    parameter int unsigned DLY = 20
) (
    input  wire logic mclk,
    input  wire logic brake_release,
    input  wire logic stuck,
    output logic      contact,
    output logic      relay_fb
);
    logic [7:0] cnt_r = '0;
    initial contact = 1'b0;
    initial relay_fb = 1'b0;
    // contact lags the coil by a travel time; stuck welds it closed
    always @(posedge mclk) begin
        relay_fb <= brake_release | stuck;
        cnt_r    <= (brake_release == contact) ? 8'd0 : cnt_r + 8'd1;
        if (stuck) begin
            contact <= 1'b1;
        end else if (cnt_r >= 8'(DLY)) begin
            contact <= brake_release;
        end
    end
endmodule

// File: sim/tb_top.sv
`timescale 1ns/1ps
// ---------------------------
// brake sequencer testbench
// ---------------------------
module tb_top;
    import brs_pkg::*;
    logic        mclk = 1'b0;
    logic        srst = 1'b1;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic        run_cmd = 1'b0;
    logic        reversal = 1'b0;
    logic        stuck = 1'b0;
    logic [1:0]  htrans = '0;
    logic [31:0] haddr = '0;
    logic [31:0] hwdata = '0;
    logic [31:0] hrdata, q;
    logic        hreadyout, hresp, brake_contact_input, relay_feedback, irq;
    logic        brake_release, reference_enable, current_ramp_down, zero_speed_hold;
    logic        brake_feedback_error, reversal_jump_frequency_en;
    int          n_mismatch = 0;
    int          n_checks = 0;
    // 0 brake, 1 ref, 2 ramp, 3 error, 4 hold, 5 irq
    wire  [5:0]  obs = {irq, zero_speed_hold, brake_feedback_error, current_ramp_down,
                        reference_enable, brake_release};
    brs_top dut (.mclk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .run_cmd, .reversal,
        .brake_contact_input, .relay_feedback(relay_feedback), .brake_release,
        .reference_enable, .current_ramp_down, .zero_speed_hold, .brake_feedback_error,
        .reversal_jump_frequency_en, .irq);
    brs_brake_model partner (.mclk, .brake_release, .stuck, .contact(brake_contact_input),
        .relay_fb(relay_feedback));
    // 40 MHz
    initial begin
        forever #12.5 mclk = ~mclk;
    end
    // ----------
    // shared tasks
    // ----------
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // one single transfer; hsel stays up so back to back calls never clash
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        int j;
        htrans <= 2'b10;
        haddr  <= {24'h0, a};
        hwrite <= w;
        for (i = 0; i < 50; i++) begin
            @(posedge mclk);
            if (hreadyout === 1'b1) break;
        end
        htrans <= 2'b00;
        hwdata <= d;
        for (j = 0; j < 50; j++) begin
            @(posedge mclk);
            if (hreadyout === 1'b1) break;
        end
        q = hrdata;
        if (i == 50 || j == 50) begin
            n_mismatch++;
            results();
        end
    endtask
    task automatic wait_obs(input int k, input logic v, input string what);
        for (int i = 0; i < 300 && obs[k] !== v; i++) @(posedge mclk);
        chk({31'h0, obs[k]}, {31'h0, v}, what);
        if (obs[k] !== v) results();
    endtask
    task automatic do_reset();
        hsel <= 1'b1;
        srst <= 1'b1;
        tick(6);
        srst <= 1'b0;
        tick(1);
    endtask
    // zero durations keep every phase short; all interrupts unmasked
    task automatic cfg();
        logic [7:0] a [5] = '{OFS_REL_DUR, OFS_ENG_DLY, OFS_ENG_DUR, OFS_RST_INT, OFS_RAMP_DUR};
        foreach (a[i]) bus(1'b1, a[i], 32'h0);
        bus(1'b1, OFS_IRQ_MASK, 32'hf);
    endtask
    task automatic run_pulse(input logic [31:0] ctl);
        bus(1'b1, OFS_CTRL, ctl);
        run_cmd <= 1'b1;
        wait_obs(1, 1'b1, "reference on");
        chk({31'h0, brake_release}, 32'h1, "released in run");
        run_cmd <= 1'b0;
    endtask
    // ----------
    // scenarios
    // ----------
    task automatic s_regs();
        logic [7:0]  a [4] = '{OFS_ENG_DLY, OFS_RST_INT, OFS_CTRL, 8'h40};
        bus(1'b1, 8'h40, 32'hffff_ffff);
        foreach (a[i]) begin
            bus(1'b0, a[i], 32'h0);
            chk(q, 32'h0, "reset value");
        end
        bus(1'b1, OFS_RST_INT, 32'h7ff);
        bus(1'b0, OFS_RST_INT, 32'h0);
        chk(q, 32'h5dc, "interval limit");
    endtask
    task automatic s_jump();
        logic [31:0] c [3] = '{32'h041, 32'h043, 32'h0c1};
        logic [31:0] e [3] = '{32'h1, 32'h0, 32'h0};
        foreach (c[i]) begin
            bus(1'b1, OFS_CTRL, c[i]);
            tick(8);
            chk({31'h0, reversal_jump_frequency_en}, e[i], "jump enable");
        end
    endtask
    task automatic s_idle();
        bus(1'b1, OFS_CTRL, 32'h0);
        run_cmd <= 1'b1;
        tick(40);
        chk({31'h0, brake_release}, 32'h0, "idle brake");
        run_cmd <= 1'b0;
        tick(8);
    endtask
    task automatic s_seq(input logic [31:0] ctl, input logic [31:0] exp);
        run_pulse(ctl);
        wait_obs(0, 1'b0, "brake engaged");
        tick(40);
        bus(1'b0, OFS_IRQ_STAT, 32'h0);
        chk({31'h0, q[IRQ_STEADY]}, exp, "steady error");
        do_reset();
        cfg();
    endtask
    task automatic s_contact();
        run_pulse(32'h119);
        chk({31'h0, brake_contact_input}, 32'h1, "contact at ref");
        wait_obs(2, 1'b1, "ramp start");
        chk({31'h0, brake_contact_input}, 32'h0, "contact at ramp");
        tick(40);
    endtask
    // new run during engage time: mode 0 passes the restart phase, mode 1 skips it
    task automatic s_mode(input logic [31:0] ctl, input logic [31:0] exp);
        bus(1'b1, OFS_IRQ_STAT, 32'hf);
        run_pulse(ctl);
        wait_obs(0, 1'b0, "engage time");
        run_cmd <= 1'b1;
        wait_obs(2, 1'b1, "full engage");
        wait_obs(1, 1'b1, "run again");
        bus(1'b0, OFS_IRQ_STAT, 32'h0);
        chk({31'h0, q[IRQ_RESTART]}, exp, "restart pass");
        run_cmd <= 1'b0;
        wait_obs(0, 1'b0, "brake engaged");
        tick(40);
    endtask
    // reversal with run held: engages when enabled, else brake stays released
    task automatic s_rev();
        logic low;
        bus(1'b1, OFS_CTRL, 32'h10b);
        run_cmd <= 1'b1;
        wait_obs(1, 1'b1, "reference on");
        reversal <= 1'b1;
        tick(3);
        reversal <= 1'b0;
        wait_obs(0, 1'b0, "reversal engage");
        wait_obs(1, 1'b1, "sequence again");
        bus(1'b1, OFS_CTRL, 32'h109);
        reversal <= 1'b1;
        tick(3);
        reversal <= 1'b0;
        low = 1'b0;
        repeat (20) begin
            @(posedge mclk);
            low = low | ~brake_release;
        end
        chk({31'h0, low}, 32'h0, "no reversal engage");
        run_cmd <= 1'b0;
        wait_obs(0, 1'b0, "brake engaged");
        tick(40);
    endtask
    task automatic s_fault();
        stuck <= 1'b1;
        run_pulse(32'h189);
        wait_obs(3, 1'b1, "feedback error");
        wait_obs(5, 1'b1, "irq raised");
        bus(1'b1, OFS_IRQ_MASK, 32'h0);
        wait_obs(5, 1'b0, "irq masked");
        bus(1'b1, OFS_IRQ_MASK, 32'hf);
        wait_obs(5, 1'b1, "irq unmasked");
        bus(1'b1, OFS_IRQ_STAT, 32'hf);
        wait_obs(5, 1'b0, "irq cleared");
        wait_obs(3, 1'b1, "error held");
        do_reset();
        cfg();
        run_pulse(32'h1a9);
        wait_obs(4, 1'b1, "zero hold");
        chk({31'h0, brake_feedback_error}, 32'h0, "no lock");
        bus(1'b0, OFS_IRQ_STAT, 32'h0);
        chk({31'h0, q[IRQ_WARN]}, 32'h1, "warning");
        stuck <= 1'b0;
    endtask
    initial begin
        do_reset();
        s_regs();
        cfg();
        s_jump();
        s_idle();
        s_seq(32'h109, 32'h0);
        s_seq(32'h101, 32'h1);
        s_contact();
        s_mode(32'h119, 32'h1);
        s_mode(32'h11d, 32'h0);
        s_rev();
        s_fault();
        results();
    end
endmodule
